// >>> design/usb_node_consts.svh
`ifndef USB_NODE_CONSTS_SVH
`define USB_NODE_CONSTS_SVH

// ****************************************************************
// Register addresses on the CPU memory bus
// ****************************************************************
`define NODE_MAIN_CONTROL_ADDR 24'hFFFD80
`define NODE_STATE_CONTROL_ADDR 24'hFFFD8A
`define MAIN_EVENT_SUMMARY_ADDR 24'hFFFD8C
`define MAIN_EVENT_MASK_ADDR 24'hFFFD8E
`define ALTERNATE_EVENT_ADDR 24'hFFFD90
`define NEGATIVE_ACK_EVENT_ADDR 24'hFFFD9C
`define FIFO_LEVEL_ALERT_ADDR 24'hFFFDA0

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_ATTACHED_BIT 3
`define STATE_FIELD_LSB 0
`define STATE_FIELD_MSB 1
`define EV_WARN_BIT 0
`define EV_ALT_BIT 1
`define EV_TX_BIT 2
`define EV_FRAME_BIT 3
`define EV_NAK_BIT 4
`define EV_LOCK_BIT 5
`define EV_RX_BIT 6
`define MASK_MASTER_BIT 7
`define EV_STICKY_SET 7'h3B

// ****************************************************************
// Reset values
// ****************************************************************
`define CTRL_RESET 8'h00
`define STATE_RESET 2'h0
`define SUMMARY_RESET 7'h00
`define MASK_RESET 8'h00
`define RDATA_RESET 8'h00

`endif

// >>> design/usb_node_pkg.sv
package usb_node_pkg;

  // Node functional states in field order: 00, 01, 10, 11.
  typedef enum logic [1:0] {
    state_bus_reset,
    state_wakeup,
    state_running,
    state_sleep
  } node_state_t;

  // Event inputs from the alternate, transmit, receive, NAK, alert and frame logic.
  typedef struct packed {
    logic fifo_alert_set;
    logic alt_set;
    logic tx_pending;
    logic frame_update;
    logic nak_set;
    logic frame_timer_unlocked;
    logic rx_pending;
    logic bus_activity;
  } node_events_t;

  // Transceiver controls.
  typedef struct packed {
    logic oe;
    logic se0;
    logic k;
    logic suspend;
  } xcvr_ctrl_t;

endpackage

// >>> design/event_flag.sv
`timescale 1ns/1ns
module event_flag
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic wipe,
  input wire logic set,
  input wire logic clr,
  // State
  output logic flag
);

  logic next_flag;

  // A set arriving with a clear keeps the flag; only a node wipe beats it.
  assign next_flag = wipe ? 1'b0 : (set | (flag & ~clr));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end

endmodule

// >>> design/usb_node_control_events.sv
// How it works
// - Disable stops clock, wipes registers, forces SE0.
// - Control: bit0 enable, bit3 attached, rest zero.
// - Detached node holds SE0 on the bus.
// - Reset or disable clears the attached bit.
// - Attached node releases bus outside wake-up, accepts hub reset.
// - Two-bit state field, clears to bus reset.
// - Bus reset state disables all endpoint pipes.
// - Wake-up state drives resume K signalling.
// - Sleep: suspend transceiver, reset endpoints, freeze rest.
// - Bus activity while sleeping raises resume flag.
// - Event summary read-only, fixed bit order, clears.
// - Alert summary set by events, cleared reading alerts.
// - Alternate summary set, cleared reading alternate register.
// - Transmit summary follows pending transmit events.
// - Frame bit on counter update, read clears.
// - NAK summary set, cleared reading NAK register.
// - Lock change on unlocked edges, read clears.
// - Receive summary follows pending receive events.
// - Summary bit 7 reads zero; mask holds master.
// - Mask bits gate events, read/write, clear.
`timescale 1ns/1ns
`include "usb_node_consts.svh"

module usb_node_control_events
  import usb_node_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // CPU memory bus
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Events from the rest of the node
  input wire node_events_t events,
  // Transceiver and node control
  output xcvr_ctrl_t xcvr,
  output logic node_clk_en,
  output logic rx_path_en,
  output logic pipes_disable,
  output logic ep_reset,
  output logic node_freeze,
  output logic resume_event,
  output logic node_irq
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [23:0] a, input logic [23:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  wire ctrl_sel = hit(cpu_addr, `NODE_MAIN_CONTROL_ADDR);
  wire state_sel = hit(cpu_addr, `NODE_STATE_CONTROL_ADDR);
  wire summary_sel = hit(cpu_addr, `MAIN_EVENT_SUMMARY_ADDR);
  wire mask_sel = hit(cpu_addr, `MAIN_EVENT_MASK_ADDR);
  wire alt_read = cpu_rd & hit(cpu_addr, `ALTERNATE_EVENT_ADDR);
  wire nak_read = cpu_rd & hit(cpu_addr, `NEGATIVE_ACK_EVENT_ADDR);
  wire alert_read = cpu_rd & hit(cpu_addr, `FIFO_LEVEL_ALERT_ADDR);
  wire summary_read = cpu_rd & summary_sel;

  // ****************************************************************
  // Control and state registers
  // ****************************************************************
  logic node_enable;
  logic node_attached;
  node_state_t node_state_field;
  logic [7:0] main_event_mask;
  logic [6:0] summary;
  logic unlocked_prev;

  localparam logic [7:0] CTRL_RST = `CTRL_RESET;
  localparam logic [6:0] SUMMARY_RST = `SUMMARY_RESET;

  wire ctrl_wr = cpu_wr & ctrl_sel;
  wire state_wr = cpu_wr & state_sel & node_enable;
  wire mask_wr = cpu_wr & mask_sel & node_enable;

  wire next_enable = ctrl_wr ? cpu_wdata[`CTRL_ENABLE_BIT] : node_enable;
  // Attach only sticks while the node stays enabled.
  wire next_attached = ctrl_wr ? (cpu_wdata[`CTRL_ATTACHED_BIT] & cpu_wdata[`CTRL_ENABLE_BIT])
                               : (node_attached & node_enable);
  // Wipe on the disabling write itself, so no register outlives the enable bit by a cycle.
  wire node_wipe = ~next_enable;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      node_enable <= CTRL_RST[`CTRL_ENABLE_BIT];
      node_attached <= CTRL_RST[`CTRL_ATTACHED_BIT];
    end
    else
    begin
      node_enable <= next_enable;
      node_attached <= next_attached;
    end
  end

  wire node_state_t next_state = node_wipe ? node_state_t'(`STATE_RESET)
                               : state_wr ? node_state_t'(cpu_wdata[`STATE_FIELD_MSB:`STATE_FIELD_LSB])
                               : node_state_field;
  wire [7:0] next_mask = node_wipe ? `MASK_RESET : mask_wr ? cpu_wdata : main_event_mask;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      node_state_field <= node_state_t'(`STATE_RESET);
      main_event_mask <= `MASK_RESET;
    end
    else
    begin
      node_state_field <= next_state;
      main_event_mask <= next_mask;
    end
  end

  // ****************************************************************
  // Main event summary
  // ****************************************************************
  // Disabling the node stops its clock, so no event may land while wiped.
  wire lock_edge = events.frame_timer_unlocked ^ unlocked_prev;
  logic [6:0] ev_set;
  logic [6:0] ev_clr;

  assign ev_set[`EV_WARN_BIT] = events.fifo_alert_set;
  assign ev_clr[`EV_WARN_BIT] = alert_read;
  assign ev_set[`EV_ALT_BIT] = events.alt_set;
  assign ev_clr[`EV_ALT_BIT] = alt_read;
  assign ev_set[`EV_TX_BIT] = events.tx_pending;
  assign ev_clr[`EV_TX_BIT] = 1'b0;
  assign ev_set[`EV_FRAME_BIT] = events.frame_update;
  assign ev_clr[`EV_FRAME_BIT] = summary_read;
  assign ev_set[`EV_NAK_BIT] = events.nak_set;
  assign ev_clr[`EV_NAK_BIT] = nak_read;
  assign ev_set[`EV_LOCK_BIT] = lock_edge;
  assign ev_clr[`EV_LOCK_BIT] = summary_read;
  assign ev_set[`EV_RX_BIT] = events.rx_pending;
  assign ev_clr[`EV_RX_BIT] = 1'b0;

  localparam logic [6:0] STICKY = `EV_STICKY_SET;

  genvar i;
  generate
    for (i = 0; i < 7; i++)
    begin : g_ev
      if (STICKY[i])
      begin : g_sticky
        event_flag u_flag (
          .clk(clk),
          .rst_n(rst_n),
          .wipe(node_wipe),
          .set(ev_set[i] & node_enable),
          .clr(ev_clr[i]),
          .flag(summary[i])
        );
      end
      else
      begin : g_level
        // Transmit and receive summaries mirror their pending level, so they clear
        // only once every status bit behind them is clear.
        logic level;

        always_ff @(posedge clk or negedge rst_n)
        begin
          if (!rst_n)
            level <= SUMMARY_RST[i];
          else
            level <= ev_set[i] & ~node_wipe;
        end

        assign summary[i] = level;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unlocked_prev <= 1'b0;
    else
      unlocked_prev <= events.frame_timer_unlocked;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire [7:0] ctrl_view = {4'h0, node_attached, 2'h0, node_enable};
  wire [7:0] state_view = {6'h00, node_state_field};
  wire [7:0] summary_view = {1'b0, summary};
  wire [7:0] next_rdata = !cpu_rd ? cpu_rdata
                        : ctrl_sel ? ctrl_view
                        : state_sel ? state_view
                        : summary_sel ? summary_view
                        : mask_sel ? main_event_mask
                        : 8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cpu_rdata <= `RDATA_RESET;
    else
      cpu_rdata <= next_rdata;
  end

  // ****************************************************************
  // Transceiver and node outputs
  // ****************************************************************
  logic st_reset;
  logic st_wake;
  logic st_sleep;

  always_comb
  begin
    st_reset = 1'b0;
    st_wake = 1'b0;
    st_sleep = 1'b0;
    unique case (node_state_field)
      state_bus_reset: st_reset = 1'b1;
      state_wakeup: st_wake = 1'b1;
      state_running: st_reset = 1'b0;
      state_sleep: st_sleep = 1'b1;
    endcase
  end

  wire force_se0 = ~node_enable | ~node_attached;
  wire drive_k = ~force_se0 & st_wake;
  wire irq_cause = main_event_mask[`MASK_MASTER_BIT] & |(summary & main_event_mask[6:0]);
  xcvr_ctrl_t next_xcvr;

  // The attached node drives only for resume K; otherwise it listens for hub reset.
  assign next_xcvr = '{oe: force_se0 | drive_k, se0: force_se0, k: drive_k, suspend: st_sleep};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xcvr <= '{oe: 1'b1, se0: 1'b1, k: 1'b0, suspend: 1'b0};
      node_clk_en <= 1'b0;
      rx_path_en <= 1'b0;
      pipes_disable <= 1'b1;
      ep_reset <= 1'b0;
      node_freeze <= 1'b0;
      resume_event <= 1'b0;
      node_irq <= 1'b0;
    end
    else
    begin
      xcvr <= next_xcvr;
      node_clk_en <= node_enable;
      rx_path_en <= ~force_se0;
      pipes_disable <= st_reset;
      ep_reset <= st_sleep;
      node_freeze <= st_sleep;
      resume_event <= st_sleep & events.bus_activity & node_enable;
      node_irq <= irq_cause;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence ev_unmasked_s;
    main_event_mask[`MASK_MASTER_BIT] && (summary & main_event_mask[6:0]) != 7'h00;
  endsequence

  sequence frame_read_s;
    summary_read && !events.frame_update;
  endsequence

  disabled_wiped_a: assert property (@(posedge clk) disable iff (!rst_n)
    !node_enable |-> !node_attached && node_state_field == state_bus_reset && main_event_mask == 8'h00
      && summary == 7'h00)
    else $error("disabled node kept register state");

  detached_se0_a: assert property (@(posedge clk) disable iff (!rst_n)
    !node_attached |=> xcvr.se0 && xcvr.oe && !xcvr.k)
    else $error("detached node not forcing SE0");

  attached_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    node_attached && node_state_field != state_wakeup |=> !xcvr.oe && rx_path_en)
    else $error("attached node still driving the bus");

  wakeup_k_a: assert property (@(posedge clk) disable iff (!rst_n)
    node_attached && node_state_field == state_wakeup |=> xcvr.k && !xcvr.se0)
    else $error("wake-up state without K signalling");

  sleep_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    node_state_field == state_sleep |=> xcvr.suspend && ep_reset && node_freeze && !pipes_disable)
    else $error("sleep state controls wrong");

  resume_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    node_enable && node_state_field == state_sleep && events.bus_activity |=> resume_event)
    else $error("bus activity in sleep lost");

  frame_read_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    frame_read_s |=> !summary[`EV_FRAME_BIT])
    else $error("frame bit survived summary read");

  frame_set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    node_enable && !node_wipe && events.frame_update |=> summary[`EV_FRAME_BIT])
    else $error("frame update lost");

  lock_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    node_enable && !node_wipe && $changed(events.frame_timer_unlocked) |=> summary[`EV_LOCK_BIT])
    else $error("lock change not flagged");

  tx_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    !events.tx_pending |=> !summary[`EV_TX_BIT])
    else $error("transmit summary stuck");

  bit7_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    summary_read |=> cpu_rdata[7] == 1'b0 && cpu_rdata[6:0] == $past(summary))
    else $error("summary read data wrong");

  irq_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    ev_unmasked_s |=> node_irq)
    else $error("unmasked event without interrupt");

  irq_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !main_event_mask[`MASK_MASTER_BIT] |=> !node_irq)
    else $error("interrupt with master enable clear");

endmodule

// >>> sim/usb_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Upstream hub port as seen by the node
// ****************************************************************
module usb_host_model
  import usb_node_pkg::*;
(
  // Node pins
  input wire xcvr_ctrl_t xcvr,
  // Test control
  input wire logic wake_req,
  // Line state towards the node
  output logic bus_activity
);
  // A port held in SE0 shows no other line state, so the hub cannot signal through it.
  assign bus_activity = wake_req & !xcvr.se0;
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import usb_node_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rd; logic [7:0] pin;} row_t;
  typedef struct packed {logic [7:0] ev; logic hold; logic [7:0] e1; logic [7:0] e2; logic [7:0] clr;} ev_row_t;
  logic clk, rst_n, cpu_rd, cpu_wr, wake, host_act;
  logic node_clk_en, rx_path_en, pipes_disable, ep_reset, node_freeze, resume_event, node_irq;
  logic [23:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, rdat;
  node_events_t ev, ev_in;
  xcvr_ctrl_t xcvr;
  integer fails, comparisons, i;
  row_t rows [12] = '{'{8'h80, 8'h09, 8'h09, 8'h20}, '{8'h80, 8'h01, 8'h01, 8'h2C}, '{8'h80, 8'h09, 8'h09, 8'h20},
    '{8'h8A, 8'h01, 8'h01, 8'h0A}, '{8'h8A, 8'h02, 8'h02, 8'h00}, '{8'h8A, 8'h03, 8'h03, 8'h11},
    '{8'h8A, 8'h00, 8'h00, 8'h20}, '{8'h8E, 8'h7F, 8'h7F, 8'h20}, '{8'h8C, 8'hFF, 8'h00, 8'h20},
    '{8'h80, 8'h01, 8'h01, 8'h2C}, '{8'h80, 8'h09, 8'h09, 8'h20}, '{8'h82, 8'h55, 8'h00, 8'h20}};
  ev_row_t erows [6] = '{'{8'h10, 1'b0, 8'h08, 8'h00, 8'h8C}, '{8'h40, 1'b0, 8'h02, 8'h02, 8'h90},
    '{8'h08, 1'b0, 8'h10, 8'h10, 8'h9C}, '{8'h80, 1'b0, 8'h01, 8'h01, 8'hA0},
    '{8'h20, 1'b1, 8'h04, 8'h04, 8'h8C}, '{8'h02, 1'b1, 8'h40, 8'h40, 8'h8C}};

  assign ev_in = {ev[7:1], host_act};

  usb_host_model host (.xcvr(xcvr), .wake_req(wake), .bus_activity(host_act));

  usb_node_control_events dut (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .events(ev_in), .xcvr(xcvr), .node_clk_en(node_clk_en),
    .rx_path_en(rx_path_en), .pipes_disable(pipes_disable), .ep_reset(ep_reset), .node_freeze(node_freeze),
    .resume_event(resume_event), .node_irq(node_irq));

  // ****************************************************************
  // Bus cycles and comparisons
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cpu_addr = {16'hFFFD, a};
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(posedge clk);
    #1;
    cpu_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    cpu_addr = {16'hFFFD, a};
    cpu_rd = 1'b1;
    @(posedge clk);
    #1;
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock and watchdog
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    fails++;
    print_verdict();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    fails = 0;
    comparisons = 0;
    rst_n = 1'b0;
    cpu_addr = 24'h000000;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_wdata = 8'h00;
    ev = 8'h00;
    wake = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_byte({2'h0, pipes_disable, ep_reset, xcvr}, 8'h2C);
    chk_bit(node_clk_en, 1'b0);
    chk_bit(rx_path_en, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      rd(8'h80 + 8'(i * 2 + (i > 0 ? 8 : 0)), rdat);
      chk_byte(rdat, 8'h00);
    end
    $display("reset values done");
    // Address enables for bus-reset entry live outside this block; the wake-up row stays only a few
    // cycles, since the block leaves that dwell to software and does not time it.
    for (i = 0; i < 12; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rdat);
      chk_byte(rdat, rows[i].rd);
      chk_byte({2'h0, pipes_disable, ep_reset, xcvr}, rows[i].pin);
    end
    chk_bit(rx_path_en, 1'b1);
    chk_bit(node_clk_en, 1'b1);
    $display("register rows done");
    wr(8'h8E, 8'hFF);
    for (i = 0; i < 6; i++)
    begin
      ev = erows[i].ev;
      @(posedge clk);
      #1;
      if (!erows[i].hold)
        ev = 8'h00;
      @(posedge clk);
      #1;
      chk_bit(node_irq, 1'b1);
      rd(8'h8C, rdat);
      chk_byte(rdat, erows[i].e1);
      rd(8'h8C, rdat);
      chk_byte(rdat, erows[i].e2);
      ev = 8'h00;
      rd(erows[i].clr, rdat);
      chk_byte(rdat, 8'h00);
      rd(8'h8C, rdat);
      chk_byte(rdat, 8'h00);
    end
    for (i = 0; i < 2; i++)
    begin
      ev[2] = ~ev[2];
      rd(8'h8C, rdat);
      chk_byte(rdat, 8'h20);
      rd(8'h8C, rdat);
      chk_byte(rdat, 8'h00);
    end
    wr(8'h8E, 8'h7F);
    ev[4] = 1'b1;
    @(posedge clk);
    #1;
    ev[4] = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_bit(node_irq, 1'b0);
    rd(8'h8C, rdat);
    chk_byte(rdat, 8'h08);
    $display("event summary done");
    wr(8'h8A, 8'h03);
    wake = 1'b1;
    @(posedge clk);
    #1;
    chk_bit(resume_event, 1'b1);
    chk_bit(node_freeze, 1'b1);
    wake = 1'b0;
    wr(8'h8A, 8'h02);
    wake = 1'b1;
    @(posedge clk);
    #1;
    chk_bit(resume_event, 1'b0);
    chk_bit(node_freeze, 1'b0);
    wake = 1'b0;
    $display("sleep and resume done");
    wr(8'h80, 8'h00);
    wr(8'h8A, 8'h02);
    wr(8'h8E, 8'hFF);
    wr(8'h80, 8'h08);
    rd(8'h8A, rdat);
    chk_byte(rdat, 8'h00);
    rd(8'h8E, rdat);
    chk_byte(rdat, 8'h00);
    rd(8'h80, rdat);
    chk_byte(rdat, 8'h00);
    chk_byte({2'h0, pipes_disable, ep_reset, xcvr}, 8'h2C);
    chk_bit(node_clk_en, 1'b0);
    $display("disable done");
    wr(8'h80, 8'h09);
    wr(8'h8A, 8'h03);
    wr(8'h8E, 8'hFF);
    ev[4] = 1'b1;
    @(posedge clk);
    #1;
    ev[4] = 1'b0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_byte({2'h0, pipes_disable, ep_reset, xcvr}, 8'h2C);
    chk_bit(node_irq, 1'b0);
    @(posedge clk);
    #1;
    chk_byte({2'h0, pipes_disable, ep_reset, xcvr}, 8'h2C);
    chk_bit(rx_path_en, 1'b0);
    rd(8'h8C, rdat);
    chk_byte(rdat, 8'h00);
    rd(8'h8A, rdat);
    chk_byte(rdat, 8'h00);
    rd(8'h8E, rdat);
    chk_byte(rdat, 8'h00);
    rd(8'h80, rdat);
    chk_byte(rdat, 8'h00);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule
